// [core/wsrs_pkg.sv]
// Constants, tables and types of the watch and standby rate selector
package wsrs_pkg;

   // ======================================================
   // Bus geometry and register indices (byte address = 4 x index)
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 7;
   localparam logic [5:0] IDX_CTRL = 6'h12;
   localparam logic [5:0] IDX_PMODE = 6'h1c;
   localparam logic [5:0] IDX_RATE = 6'h20;
   localparam logic [5:0] IDX_STAT = 6'h21;

   // ======================================================
   // Field positions and reset values
   localparam int WSR_LSB = 0;
   localparam int WSR_MSB = 3;
   localparam int ZERO_BIT = 4;
   localparam int STB_LSB = 5;
   localparam int STB_MSB = 7;
   localparam int PM_LSB = 4;
   localparam int PM_MSB = 6;
   localparam logic [3:0] WSR_RST = 4'h0;
   localparam logic [2:0] STB_RST = 3'h0;
   localparam logic [2:0] PM_RST = 3'h0;

   // ======================================================
   // Power modes and special watch codes
   localparam logic [2:0] PM_LOW = 3'h0;
   localparam logic [2:0] PM_ULP = 3'h3;
   localparam logic [2:0] PM_PREC = 3'h4;
   localparam logic [3:0] WATCH_DEFAULT = 4'h0;
   localparam logic [3:0] WATCH_DEFAULT_ALIAS = 4'h4;
   localparam logic [3:0] WATCH_CUSTOM = 4'hf;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ======================================================
   // Rates in units of 0.1 Hz; zero marks a code not valid in the mode
   localparam logic [15:0] WATCH_ULP [16] = '{
      16'h0000, 16'h0004, 16'h0008, 16'h000f, 16'h003c, 16'h0082,
      16'h00fa, 16'h01f4, 16'h03e8, 16'h076c, 16'h0ed8, 16'h1d4c,
      16'h2af8, 16'h0000, 16'h0000, 16'h32c8};
   localparam logic [15:0] WATCH_LOW [16] = '{
      16'h0000, 16'h0004, 16'h0008, 16'h000f, 16'h0046, 16'h008c,
      16'h0118, 16'h021c, 16'h041a, 16'h0834, 16'h0fa0, 16'h1770,
      16'h0000, 16'h0000, 16'h0000, 16'h1d4c};
   localparam logic [15:0] WATCH_PREC [16] = '{
      16'h0000, 16'h0002, 16'h0004, 16'h0009, 16'h0046, 16'h008c,
      16'h0118, 16'h0226, 16'h0320, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h03e8};
   localparam logic [15:0] STBY_ULP [8] = '{
      16'h000a, 16'h001e, 16'h0032, 16'h0064,
      16'h00e6, 16'h01c2, 16'h0384, 16'h0708};
   localparam logic [15:0] STBY_LOW [8] = '{
      16'h0005, 16'h000a, 16'h001e, 16'h003c,
      16'h0078, 16'h00f0, 16'h01e0, 16'h03e8};
   localparam logic [15:0] STBY_PREC [8] = '{
      16'h0001, 16'h0002, 16'h0004, 16'h0008,
      16'h000f, 16'h001e, 16'h0032, 16'h0064};

   typedef enum logic [1:0] {
      RD_IDLE = 2'b01,
      RD_DATA = 2'b10
   } wsrs_rd_e;

endpackage : wsrs_pkg

// [core/wsrs_rate_lut.sv]
// Registered lookup of watch and standby rates from codes and power mode
`timescale 1ns/1ps
module wsrs_rate_lut (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [2:0] pmode,
   input wire logic [3:0] watch_code,
   input wire logic [2:0] stby_code,
   output logic [15:0] watch_rate,
   output logic [15:0] stby_rate,
   output logic watch_invalid,
   output logic watch_custom
);

   logic [3:0] eff_code;
   logic [15:0] next_watch_rate;
   logic [15:0] next_stby_rate;
   logic next_watch_invalid;
   logic next_watch_custom;

   // ======================================================
   // Table selection
   always_comb
   begin
      eff_code = (watch_code == wsrs_pkg::WATCH_DEFAULT) ?
         wsrs_pkg::WATCH_DEFAULT_ALIAS : watch_code;
      case (pmode)
         wsrs_pkg::PM_ULP:
         begin
            next_watch_rate = wsrs_pkg::WATCH_ULP[eff_code];
            next_stby_rate = wsrs_pkg::STBY_ULP[stby_code];
         end
         wsrs_pkg::PM_LOW:
         begin
            next_watch_rate = wsrs_pkg::WATCH_LOW[eff_code];
            next_stby_rate = wsrs_pkg::STBY_LOW[stby_code];
         end
         wsrs_pkg::PM_PREC:
         begin
            next_watch_rate = wsrs_pkg::WATCH_PREC[eff_code];
            next_stby_rate = wsrs_pkg::STBY_PREC[stby_code];
         end
         default:
         begin
            next_watch_rate = 16'h0000;
            next_stby_rate = 16'h0000;
         end
      endcase
      next_watch_invalid = (next_watch_rate == 16'h0000);
      next_watch_custom = (watch_code == wsrs_pkg::WATCH_CUSTOM) &&
         !next_watch_invalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         watch_rate <= 16'h0000;
         stby_rate <= 16'h0000;
         watch_invalid <= 1'b0;
         watch_custom <= 1'b0;
      end
      else
      begin
         watch_rate <= next_watch_rate;
         stby_rate <= next_stby_rate;
         watch_invalid <= next_watch_invalid;
         watch_custom <= next_watch_custom;
      end
   end

   // ======================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_prec_rate_pick: assert property (
      (pmode == wsrs_pkg::PM_PREC && watch_code == 4'h8)
      |=> watch_rate == 16'h0320)
      else $error("precision watch rate wrong");
   a_stby_slowest: assert property (
      (pmode == wsrs_pkg::PM_LOW && stby_code == 3'h0)
      |=> stby_rate == 16'h0005)
      else $error("standby default rate wrong");
   a_default_alias: assert property (
      (pmode == wsrs_pkg::PM_ULP && watch_code == 4'h0)
      |=> watch_rate == 16'h003c && !watch_invalid)
      else $error("default watch code not aliased");
   a_bad_codes: assert property (
      (watch_code == 4'hd || watch_code == 4'he) |=> watch_invalid)
      else $error("reserved watch code accepted");
   a_ulp_only_code: assert property (
      watch_code == 4'hc
      |=> watch_invalid == ($past(pmode) != wsrs_pkg::PM_ULP))
      else $error("code 1100 validity wrong");

endmodule : wsrs_rate_lut

// [core/wsrs_rate_select.sv]
// Watch and standby rate control register with AXI4-Lite access
//
// Behaviour
// - Bits 3..0 pick the sample rate used in activity-watch mode.
// - Bits 7..5 pick the clock rate used in standby.
// - Power mode 3 ultra-low, 0 low, 4 precision selects the rate table.
// - Standby codes 0..7 give eight rising rates; code 0 is slowest.
// - Watch code 0 equals code 4; 13,14 invalid; 12 only ultra-low.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
module wsrs_rate_select (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [3:0] watch_sample_rate_code,
   output logic [2:0] standby_clock_rate_code,
   output logic [2:0] power_mode,
   output logic [15:0] watch_rate_dhz,
   output logic [15:0] standby_rate_dhz,
   output logic watch_rate_invalid,
   output logic watch_rate_custom
);

   // ======================================================
   // Write channel state
   logic aw_hold;
   logic w_hold;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic next_aw_hold;
   logic next_w_hold;
   logic [7:0] next_awaddr_q;
   logic [31:0] next_wdata_q;
   logic [3:0] next_wstrb_q;
   logic next_bvalid_q;
   logic [1:0] next_bresp_q;

   logic aw_ok;
   logic w_ok;
   logic wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [5:0] wr_idx;
   logic ctrl_wr;
   logic pmode_wr;

   // ======================================================
   // Register state
   logic [3:0] next_watch_code;
   logic [2:0] next_stby_code;
   logic [2:0] next_power_mode;
   logic [7:0] ctrl_rd;

   // ======================================================
   // Read channel state
   wsrs_pkg::wsrs_rd_e rd_state;
   wsrs_pkg::wsrs_rd_e next_rd_state;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [5:0] rd_idx;

   assign s_axi_awready = !aw_hold && !bvalid_q;
   assign s_axi_wready = !w_hold && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = (rd_state == wsrs_pkg::RD_IDLE);
   assign s_axi_rvalid = (rd_state == wsrs_pkg::RD_DATA);

   // ======================================================
   // Write path: address and data accepted in either order
   always_comb
   begin
      aw_ok = aw_hold || (s_axi_awvalid && s_axi_awready);
      w_ok = w_hold || (s_axi_wvalid && s_axi_wready);
      wr_fire = aw_ok && w_ok;
      wr_addr = aw_hold ? awaddr_q : s_axi_awaddr;
      wr_data = w_hold ? wdata_q : s_axi_wdata;
      wr_strb = w_hold ? wstrb_q : s_axi_wstrb;
      wr_idx = wr_addr[wsrs_pkg::IDX_MSB:wsrs_pkg::IDX_LSB];
      ctrl_wr = wr_fire && (wr_idx == wsrs_pkg::IDX_CTRL) && wr_strb[0];
      pmode_wr = wr_fire && (wr_idx == wsrs_pkg::IDX_PMODE) &&
         wr_strb[0];

      next_aw_hold = aw_hold;
      next_w_hold = w_hold;
      next_awaddr_q = awaddr_q;
      next_wdata_q = wdata_q;
      next_wstrb_q = wstrb_q;
      next_bvalid_q = bvalid_q;
      next_bresp_q = bresp_q;
      next_watch_code = watch_sample_rate_code;
      next_stby_code = standby_clock_rate_code;
      next_power_mode = power_mode;

      if (bvalid_q && s_axi_bready)
      begin
         next_bvalid_q = 1'b0;
      end
      if (wr_fire)
      begin
         next_aw_hold = 1'b0;
         next_w_hold = 1'b0;
         next_bvalid_q = 1'b1;
         if (wr_idx == wsrs_pkg::IDX_CTRL ||
             wr_idx == wsrs_pkg::IDX_PMODE)
         begin
            next_bresp_q = wsrs_pkg::RESP_OKAY;
         end
         else
         begin
            next_bresp_q = wsrs_pkg::RESP_SLVERR;
         end
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            next_aw_hold = 1'b1;
            next_awaddr_q = s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            next_w_hold = 1'b1;
            next_wdata_q = s_axi_wdata;
            next_wstrb_q = s_axi_wstrb;
         end
      end

      if (ctrl_wr)
      begin
         next_watch_code = wr_data[wsrs_pkg::WSR_MSB:wsrs_pkg::WSR_LSB];
         next_stby_code = wr_data[wsrs_pkg::STB_MSB:wsrs_pkg::STB_LSB];
      end
      if (pmode_wr)
      begin
         next_power_mode = wr_data[wsrs_pkg::PM_MSB:wsrs_pkg::PM_LSB];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= wsrs_pkg::RESP_OKAY;
         watch_sample_rate_code <= wsrs_pkg::WSR_RST;
         standby_clock_rate_code <= wsrs_pkg::STB_RST;
         power_mode <= wsrs_pkg::PM_RST;
      end
      else
      begin
         aw_hold <= next_aw_hold;
         w_hold <= next_w_hold;
         awaddr_q <= next_awaddr_q;
         wdata_q <= next_wdata_q;
         wstrb_q <= next_wstrb_q;
         bvalid_q <= next_bvalid_q;
         bresp_q <= next_bresp_q;
         watch_sample_rate_code <= next_watch_code;
         standby_clock_rate_code <= next_stby_code;
         power_mode <= next_power_mode;
      end
   end

   // ======================================================
   // Read path
   always_comb
   begin
      ctrl_rd = {standby_clock_rate_code, 1'b0, watch_sample_rate_code};
      rd_idx = s_axi_araddr[wsrs_pkg::IDX_MSB:wsrs_pkg::IDX_LSB];
      rd_hit = 1'b1;
      case (rd_idx)
         wsrs_pkg::IDX_CTRL: rd_mux = {24'h00_0000, ctrl_rd};
         wsrs_pkg::IDX_PMODE: rd_mux = {25'h000_0000, power_mode, 4'h0};
         wsrs_pkg::IDX_RATE: rd_mux = {standby_rate_dhz, watch_rate_dhz};
         wsrs_pkg::IDX_STAT:
            rd_mux = {30'h0000_0000, watch_rate_custom, watch_rate_invalid};
         default:
         begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase

      next_rd_state = rd_state;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      case (rd_state)
         wsrs_pkg::RD_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               next_rd_state = wsrs_pkg::RD_DATA;
               next_rdata = rd_mux;
               next_rresp = rd_hit ? wsrs_pkg::RESP_OKAY :
                  wsrs_pkg::RESP_SLVERR;
            end
         end
         wsrs_pkg::RD_DATA:
         begin
            if (s_axi_rready)
            begin
               next_rd_state = wsrs_pkg::RD_IDLE;
            end
         end
         default:
         begin
            next_rd_state = wsrs_pkg::RD_IDLE;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state <= wsrs_pkg::RD_IDLE;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= wsrs_pkg::RESP_OKAY;
      end
      else
      begin
         rd_state <= next_rd_state;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // ======================================================
   // Rate lookup
   wsrs_rate_lut u_lut (
      .aclk(aclk),
      .aresetn(aresetn),
      .pmode(power_mode),
      .watch_code(watch_sample_rate_code),
      .stby_code(standby_clock_rate_code),
      .watch_rate(watch_rate_dhz),
      .stby_rate(standby_rate_dhz),
      .watch_invalid(watch_rate_invalid),
      .watch_custom(watch_rate_custom)
   );

   // ======================================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_watch_code_wr: assert property (
      ctrl_wr |=> watch_sample_rate_code == $past(wr_data[3:0]))
      else $error("watch code not taken from write");
   a_stby_code_wr: assert property (
      ctrl_wr |=> standby_clock_rate_code == $past(wr_data[7:5]))
      else $error("standby code not taken from write");
   a_zero_bit_rd: assert property (
      (s_axi_arvalid && s_axi_arready && rd_idx == wsrs_pkg::IDX_CTRL)
      |=> s_axi_rvalid && s_axi_rdata[4] == 1'b0 &&
          s_axi_rdata[7:5] == $past(standby_clock_rate_code))
      else $error("control readback wrong");
   a_mode_to_rate: assert property (
      (pmode_wr && wr_data[6:4] == wsrs_pkg::PM_ULP &&
       watch_sample_rate_code == 4'hc && !ctrl_wr)
      |=> ##1 !watch_rate_invalid && watch_rate_dhz == 16'h2af8)
      else $error("power mode did not steer rate");
   a_write_resp: assert property (
      wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write response missing");

   c_ctrl_write: cover property (ctrl_wr);
   c_ctrl_read: cover property (
      s_axi_rvalid && s_axi_rready && s_axi_rresp == wsrs_pkg::RESP_OKAY);
   c_custom_rate: cover property (watch_rate_custom);
   c_invalid_code: cover property (watch_rate_invalid);

endmodule : wsrs_rate_select

// [verif/test_watch_standby_rate_select.sv]
// Register-level bench for the watch and standby rate selector
`timescale 1ns/1ps
module test_watch_standby_rate_select;
   // ======================================================
   // Clock, reset and bus signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] wcode;
   logic [2:0] scode, pmode;
   logic [15:0] wrate, srate;
   logic winv, wcus;
   int fail_count = 0, n_checks = 0, cyc = 0;
   logic [1:0] resp;
   logic [31:0] rd;
   logic [2:0] modes [4];
   logic [15:0] ew, es, prev;
   logic [7:0] cv;
   logic inv, cus;

   always #2.5 aclk = ~aclk;

   wsrs_rate_select u_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .watch_sample_rate_code(wcode), .standby_clock_rate_code(scode),
      .power_mode(pmode), .watch_rate_dhz(wrate),
      .standby_rate_dhz(srate), .watch_rate_invalid(winv),
      .watch_rate_custom(wcus)
   );

   // ======================================================
   // Verdict and hang guard
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : close_out

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count = fail_count + 1;
         $display("mismatch at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk

   // ======================================================
   // Bus master tasks
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                            input logic [3:0] s, output logic [1:0] r);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_read

   // ======================================================
   // Expected rates from the mode tables
   function automatic logic [15:0] exp_w(input logic [2:0] m,
                                         input logic [3:0] w);
      logic [3:0] i;
      i = (w == wsrs_pkg::WATCH_DEFAULT) ? wsrs_pkg::WATCH_DEFAULT_ALIAS : w;
      case (m)
         wsrs_pkg::PM_ULP: return wsrs_pkg::WATCH_ULP[i];
         wsrs_pkg::PM_LOW: return wsrs_pkg::WATCH_LOW[i];
         wsrs_pkg::PM_PREC: return wsrs_pkg::WATCH_PREC[i];
         default: return 16'h0000;
      endcase
   endfunction : exp_w

   function automatic logic [15:0] exp_s(input logic [2:0] m,
                                         input logic [2:0] s);
      case (m)
         wsrs_pkg::PM_ULP: return wsrs_pkg::STBY_ULP[s];
         wsrs_pkg::PM_LOW: return wsrs_pkg::STBY_LOW[s];
         wsrs_pkg::PM_PREC: return wsrs_pkg::STBY_PREC[s];
         default: return 16'h0000;
      endcase
   endfunction : exp_s

   // ======================================================
   // Test sequence
   initial
   begin
      modes = '{wsrs_pkg::PM_LOW, wsrs_pkg::PM_ULP, wsrs_pkg::PM_PREC, 3'h1};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(8'h48, rd, resp);
      chk(rd, 32'h0, "control reset");
      axi_read(8'h70, rd, resp);
      chk(rd, 32'h0, "power mode reset");
      ew = wsrs_pkg::WATCH_LOW[4];
      chk({16'h0, wrate}, {16'h0, ew}, "reset watch");
      es = wsrs_pkg::STBY_LOW[0];
      chk({16'h0, srate}, {16'h0, es}, "reset stby");
      $display("test reset done");

      for (int m = 0; m < 4; m++)
      begin
         axi_write(8'h70, {25'h0, modes[m], 4'h0}, 4'h1, resp);
         chk({30'h0, resp}, {30'h0, wsrs_pkg::RESP_OKAY}, "pmode bresp");
         for (int w = 0; w < 16; w++)
         begin
            cv = {w[2:0], 1'b0, w[3:0]};
            axi_write(8'h48, {24'h0, cv}, 4'h1, resp);
            axi_read(8'h48, rd, resp);
            chk(rd, {24'h0, cv}, "control readback");
            chk({28'h0, wcode}, {28'h0, cv[3:0]}, "watch code");
            chk({29'h0, scode}, {29'h0, cv[7:5]}, "stby code");
            chk({29'h0, pmode}, {29'h0, modes[m]}, "power mode");
            ew = exp_w(modes[m], cv[3:0]);
            es = exp_s(modes[m], cv[7:5]);
            inv = (ew == 16'h0);
            cus = (w == 15) && !inv;
            chk({16'h0, wrate}, {16'h0, ew}, "watch rate");
            chk({16'h0, srate}, {16'h0, es}, "stby rate");
            chk({31'h0, winv}, {31'h0, inv}, "invalid flag");
            chk({31'h0, wcus}, {31'h0, cus}, "custom");
            if (m < 3 && cv[7:5] != 3'h0)
            begin
               chk({31'h0, srate > prev}, 32'h1, "stby rising");
            end
            prev = srate;
            axi_read(8'h80, rd, resp);
            chk(rd, {es, ew}, "rate readback");
            axi_read(8'h84, rd, resp);
            chk(rd, {30'h0, cus, inv}, "status");
         end
      end
      $display("test code sweep done");

      axi_write(8'h48, 32'hbc, 4'h1, resp);
      axi_write(8'h70, 32'h30, 4'h1, resp);
      axi_read(8'h48, rd, resp);
      chk(rd, 32'hac, "bit4 dropped");
      chk({31'h0, winv}, 32'h0, "code 12 ulp");
      ew = wsrs_pkg::WATCH_ULP[12];
      chk({16'h0, wrate}, {16'h0, ew}, "code 12 rate");
      axi_write(8'h48, 32'h77, 4'h0, resp);
      chk({30'h0, resp}, {30'h0, wsrs_pkg::RESP_OKAY}, "no strobe bresp");
      axi_read(8'h48, rd, resp);
      chk(rd, 32'hac, "no strobe kept");
      axi_write(8'h80, 32'h55, 4'h1, resp);
      chk({30'h0, resp}, {30'h0, wsrs_pkg::RESP_SLVERR}, "ro write");
      axi_write(8'hfc, 32'h55, 4'h1, resp);
      chk({30'h0, resp}, {30'h0, wsrs_pkg::RESP_SLVERR}, "unmapped write");
      axi_read(8'hfc, rd, resp);
      chk({30'h0, resp}, {30'h0, wsrs_pkg::RESP_SLVERR}, "unmapped read");
      chk(rd, 32'h0, "unmapped data");
      axi_read(8'h48, rd, resp);
      chk(rd, 32'hac, "after errors");
      $display("test refusals done");

      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axi_read(8'h48, rd, resp);
      chk(rd, 32'h0, "control after reset");
      ew = wsrs_pkg::WATCH_LOW[4];
      chk({16'h0, wrate}, {16'h0, ew}, "watch after rst");
      $display("test second reset done");
      close_out();
   end
endmodule : test_watch_standby_rate_select
